// ### ioport_params.svh
// Constants for the I/O-port control register window: offsets, resets,
// decoder term layout and the width of the sampled pin bundle.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IOPORT_PARAMS_SVH
`define IOPORT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets inside the port region (low five address bits)
// ----------------------------------------------------------------------
`define OFF_PIN_A 5'h02
`define OFF_PIN_B 5'h03
`define OFF_DIR_A 5'h04
`define OFF_DIR_B 5'h05
`define OFF_LATCH_A 5'h06
`define OFF_LATCH_B 5'h07
`define OFF_POWER 5'h10
`define OFF_PAGE 5'h18
`define REGION_BYTES 24

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DIR_RESET 8'h00
`define LATCH_RESET 8'h00
`define POWER_RESET 8'h00
`define PAGE_RESET 8'h00
`define PIN_RESET 8'h00

// ----------------------------------------------------------------------
// Product-term array layout
// ----------------------------------------------------------------------
`define DEC_W 11
`define TERM_COUNT 28
`define WIDE_TERMS 4
`define NARROW_BASE 16
`define NARROW_TERMS 2
`define SINGLE_BASE 24
`define REGION_TERM 27

// ----------------------------------------------------------------------
// Sampled pin bundle: rd, wr, bhe_n, wide, addr, wdata, port C, A, B
// ----------------------------------------------------------------------
`define SAMPLE_W 55

`endif

// ### ioport_pkg.sv
// Types shared by the I/O-port register window design.
// Assumes ioport_params.svh is on the include path.
`include "ioport_params.svh"

package ioport_pkg;

   // Two-stage synchroniser state.
   typedef struct packed {
      logic [`SAMPLE_W-1:0] meta;
      logic [`SAMPLE_W-1:0] stable;
   } sampler_state_t;

   // Complete state of the register window.
   typedef struct packed {
      logic rd_prev;
      logic wr_prev;
      logic [7:0] pin_a;
      logic [7:0] pin_b;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [7:0] latch_a;
      logic [7:0] latch_b;
      logic [7:0] power;
      logic [7:0] page;
      logic [15:0] rdata;
      logic rdata_oe;
      logic [3:0] wide_cs;
      logic [3:0] narrow_cs;
      logic [2:0] single_cs;
      logic [7:0] pa_out;
      logic [7:0] pa_oe;
      logic [7:0] pb_out;
      logic [7:0] pb_oe;
      logic [2:0] pc_out;
      logic [2:0] pc_oe;
   } window_state_t;

   // Register addressed by the current access.
   typedef enum {REG_NONE, REG_PIN, REG_DIR, REG_LATCH, REG_POWER, REG_PAGE} reg_kind_t;

endpackage

// ### port_pin_sampler.sv
// Two flip-flop synchroniser for every asynchronous pin of the block.
// Assumes the raw bundle comes straight from pads; only stable is read.
`timescale 1ns/10ps
`include "ioport_params.svh"

module port_pin_sampler (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [`SAMPLE_W-1:0] raw,
   output logic [`SAMPLE_W-1:0] stable
);
   import ioport_pkg::*;

   ioport_pkg::sampler_state_t st_q;
   ioport_pkg::sampler_state_t st_d;

   // The first stage feeds only the second, so metastability settles there.
   always_comb begin
      st_d = st_q;
      st_d.meta = raw;
      st_d.stable = st_q.meta;
   end

   // Synchronous reset clears both stages.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign stable = st_q.stable;
endmodule

// ### cs_term_array.sv
// Programmable product-term array over the decoder inputs.
// Assumes care and match come from static configuration, not the bus.
`timescale 1ns/10ps
`include "ioport_params.svh"

module cs_term_array (
   input wire logic [`DEC_W-1:0] dec_in,
   input wire logic [`TERM_COUNT-1:0][`DEC_W-1:0] term_care,
   input wire logic [`TERM_COUNT-1:0][`DEC_W-1:0] term_match,
   output logic [`TERM_COUNT-1:0] hits
);
   import ioport_pkg::*;

   // A term is true when every cared-for input equals its match bit.
   always_comb begin
      for (int t = 0; t < `TERM_COUNT; t++) begin
         hits[t] = (((dec_in ^ term_match[t]) & term_care[t]) == '0);
      end
   end
endmodule

// ### io_port_control_register_decode.sv
// I/O-port control register window with the secondary chip-select terms.
// Assumes a host on an 8-bit or 16-bit bus whose strobes are asynchronous.
`timescale 1ns/10ps
`include "ioport_params.svh"

module io_port_control_register_decode #(
   parameter bit HAS_POWER_REG = 1'b1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic bus_wide,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic bus_high_enable_n,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   output logic rdata_oe,
   input wire logic [`TERM_COUNT-1:0][`DEC_W-1:0] term_care,
   input wire logic [`TERM_COUNT-1:0][`DEC_W-1:0] term_match,
   input wire logic [7:0] route_b,
   input wire logic [2:0] route_c,
   input wire logic [7:0] port_a_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   input wire logic [2:0] port_c_in,
   output logic [2:0] port_c_out,
   output logic [2:0] port_c_oe,
   output logic [3:0] wide_term_selects,
   output logic [3:0] narrow_term_selects,
   output logic [2:0] single_term_selects,
   output logic [7:0] power_saving_control,
   output logic [7:0] page_select
);
   import ioport_pkg::*;

   // ------------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------------
   logic [`SAMPLE_W-1:0] raw;
   logic [`SAMPLE_W-1:0] stable;
   logic rd_s;
   logic wr_s;
   logic bhe_n_s;
   logic wide_s;
   logic [15:0] addr_s;
   logic [15:0] wdata_s;
   logic [2:0] pc_s;
   logic [7:0] pa_s;
   logic [7:0] pb_s;

   // Bus strobes, address, data and pins all arrive from pads.
   assign raw = {rd_strobe, wr_strobe, bus_high_enable_n, bus_wide, addr, wdata,
                 port_c_in, port_a_in, port_b_in};
   assign {rd_s, wr_s, bhe_n_s, wide_s, addr_s, wdata_s, pc_s, pa_s, pb_s} = stable;

   port_pin_sampler sampler (
      .core_clk(core_clk),
      .reset(reset),
      .raw(raw),
      .stable(stable)
   );

   // ------------------------------------------------------------------
   // Product terms
   // ------------------------------------------------------------------
   logic [`DEC_W-1:0] dec_in;
   logic [`TERM_COUNT-1:0] hits;
   logic [3:0] wide_or;
   logic [3:0] narrow_or;
   logic [2:0] single_or;
   logic port_region_select;

   // Port C bits extend the upper address lines, refining the boundary.
   // finer region decode
   assign dec_in = {addr_s[15:8], pc_s};

   cs_term_array terms (
      .dec_in(dec_in),
      .term_care(term_care),
      .term_match(term_match),
      .hits(hits)
   );

   // Sum the terms of each select group.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wide_or[i] = |hits[i*`WIDE_TERMS +: `WIDE_TERMS];
         narrow_or[i] = |hits[`NARROW_BASE + i*`NARROW_TERMS +: `NARROW_TERMS];
      end
      single_or = hits[`SINGLE_BASE +: 3];
   end

   assign port_region_select = hits[`REGION_TERM];

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   // Selects the byte lanes: on a wide bus the even address carries port A
   // on the low lane and the enable carries port B on the high lane.
   function automatic logic [1:0] lane_sel(input logic wide, input logic a0,
                                          input logic bhe_n);
      logic [1:0] sel;
      if (wide) begin
         sel = {~bhe_n, ~a0};
      end else begin
         sel = {a0, ~a0};
      end
      return sel;
   endfunction

   // Maps the low offset bits onto the register kind.
   function automatic reg_kind_t kind_of(input logic [4:0] off, input logic wide);
      reg_kind_t k;
      case ({off[4:1], 1'b0})
         `OFF_PIN_A: k = REG_PIN;
         `OFF_DIR_A: k = REG_DIR;
         `OFF_LATCH_A: k = REG_LATCH;
         `OFF_POWER: k = (HAS_POWER_REG && (wide || !off[0])) ? REG_POWER : REG_NONE;
         `OFF_PAGE: k = (wide || !off[0]) ? REG_PAGE : REG_NONE;
         default: k = REG_NONE;
      endcase
      return k;
   endfunction

   logic [4:0] off;
   reg_kind_t kind;
   logic [1:0] sel;
   logic mapped;
   logic wr_pulse;
   window_state_t q;
   window_state_t d;

   always_comb begin
      off = addr_s[4:0];
      kind = kind_of(off, wide_s);
      sel = lane_sel(wide_s, off[0], bhe_n_s);
      mapped = port_region_select && (kind != REG_NONE) &&
               ((kind == REG_POWER) || (kind == REG_PAGE) || (sel != 2'b00));
      wr_pulse = wr_s && !q.wr_prev;
   end

   // ------------------------------------------------------------------
   // State update
   // ------------------------------------------------------------------
   logic [7:0] wr_a;
   logic [7:0] wr_b;

   // All state is computed here; outputs are direct flop copies.
   always_comb begin
      d = q;
      wr_a = wdata_s[7:0];
      wr_b = wide_s ? wdata_s[15:8] : wdata_s[7:0];
      d.rd_prev = rd_s;
      d.wr_prev = wr_s;
      d.pin_a = pa_s;
      d.pin_b = pb_s;
      if (wr_pulse && mapped) begin
         case (kind)
            REG_DIR: begin
               if (sel[0]) d.dir_a = wr_a;
               if (sel[1]) d.dir_b = wr_b;
            end
            REG_LATCH: begin
               if (sel[0]) d.latch_a = wr_a;
               if (sel[1]) d.latch_b = wr_b;
            end
            REG_POWER: d.power = wr_a;
            REG_PAGE: d.page = wr_a;
            default: d.page = q.page;
         endcase
      end
      // Read data is refreshed every cycle so a held strobe sees live pins.
      d.rdata = '0;
      d.rdata_oe = rd_s && mapped && !wr_s;
      case (kind)
         REG_PIN: begin
            if (sel[0]) d.rdata[7:0] = q.pin_a;
            if (sel[1] && wide_s) d.rdata[15:8] = q.pin_b;
            if (sel[1] && !wide_s) d.rdata[7:0] = q.pin_b;
         end
         REG_DIR: begin
            if (sel[0]) d.rdata[7:0] = q.dir_a;
            if (sel[1] && wide_s) d.rdata[15:8] = q.dir_b;
            if (sel[1] && !wide_s) d.rdata[7:0] = q.dir_b;
         end
         REG_LATCH: begin
            if (sel[0]) d.rdata[7:0] = q.latch_a;
            if (sel[1] && wide_s) d.rdata[15:8] = q.latch_b;
            if (sel[1] && !wide_s) d.rdata[7:0] = q.latch_b;
         end
         REG_POWER: d.rdata[7:0] = q.power;
         REG_PAGE: d.rdata[7:0] = q.page;
         default: d.rdata = '0;
      endcase
      d.wide_cs = wide_or;
      d.narrow_cs = narrow_or;
      d.single_cs = single_or;
      d.pa_out = q.latch_a;
      d.pa_oe = q.dir_a;
      for (int i = 0; i < 8; i++) begin
         if (route_b[i]) begin
            d.pb_out[i] = (i < 4) ? q.wide_cs[i[1:0]] : q.narrow_cs[i[1:0]];
         end else begin
            d.pb_out[i] = q.latch_b[i];
         end
      end
      d.pb_oe = q.dir_b | route_b;
      d.pc_out = q.single_cs;
      d.pc_oe = route_c;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= '0;
         q.dir_a <= `DIR_RESET;
         q.dir_b <= `DIR_RESET;
         q.latch_a <= `LATCH_RESET;
         q.latch_b <= `LATCH_RESET;
         q.power <= `POWER_RESET;
         q.page <= `PAGE_RESET;
         q.pin_a <= `PIN_RESET;
         q.pin_b <= `PIN_RESET;
      end else begin
         q <= d;
      end
   end

   // Flop copies onto the ports.
   assign rdata = q.rdata;
   assign rdata_oe = q.rdata_oe;
   assign port_a_out = q.pa_out;
   assign port_a_oe = q.pa_oe;
   assign port_b_out = q.pb_out;
   assign port_b_oe = q.pb_oe;
   assign port_c_out = q.pc_out;
   assign port_c_oe = q.pc_oe;
   assign wide_term_selects = q.wide_cs;
   assign narrow_term_selects = q.narrow_cs;
   assign single_term_selects = q.single_cs;
   assign power_saving_control = q.power;
   assign page_select = q.page;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   AST_WIDE_SUM: assert property (@(posedge core_clk) disable iff (reset)
      (|hits[3:0]) |=> wide_term_selects[0] ##1 (!$past(route_b[0]) || port_b_out[0]))
      else $error("Wide select 0 missed a true term.");

   AST_NARROW_SUM: assert property (@(posedge core_clk) disable iff (reset)
      !(hits[`NARROW_BASE] || hits[`NARROW_BASE + 1]) |=> !narrow_term_selects[0])
      else $error("Narrow select 0 set without a true term.");

   AST_SINGLE_TERM: assert property (@(posedge core_clk) disable iff (reset)
      hits[`SINGLE_BASE] |=> single_term_selects[0] ##1 (port_c_out[0]))
      else $error("Single select 0 did not follow its term.");

   AST_ROUTE_DRIVES: assert property (@(posedge core_clk) disable iff (reset)
      1'b1 |=> (port_c_oe == $past(route_c)))
      else $error("Routed port C pin not enabled.");

   AST_REGION_GATE: assert property (@(posedge core_clk) disable iff (reset)
      !port_region_select |=> !rdata_oe)
      else $error("Read answered outside the port region.");

   AST_PIN_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (reset)
      (wr_pulse && kind == REG_PIN) |=> ($stable(q.dir_a) && $stable(q.latch_a) &&
                                         $stable(q.dir_b) && $stable(q.latch_b)))
      else $error("Pin-level write changed a register.");

   AST_RESET_CLEARS: assert property (@(posedge core_clk)
      $past(reset) |-> (port_a_oe == 8'h00 && q.latch_a == 8'h00 && q.dir_b == 8'h00))
      else $error("Direction or latch not cleared by reset.");

   AST_PIN_LEVEL: assert property (@(posedge core_clk) disable iff (reset)
      1'b1 |=> (q.pin_a == $past(pa_s)))
      else $error("Pin level does not follow the sampled pad.");

   AST_HIGH_LANE_GUARD: assert property (@(posedge core_clk) disable iff (reset)
      (wr_pulse && wide_s && bhe_n_s) |=> $stable(q.latch_b) && $stable(q.dir_b))
      else $error("Port B byte written with enable high.");

   AST_NARROW_LATCH_A: assert property (@(posedge core_clk) disable iff (reset)
      (wr_pulse && port_region_select && !wide_s && off == `OFF_LATCH_A)
      |=> (q.latch_a == $past(wdata_s[7:0])) ##2 (port_a_out == $past(wdata_s[7:0], 3)))
      else $error("Narrow port A latch write lost.");
endmodule

// ### host_bus_model.sv
// Host microcontroller model that runs read and write strobe cycles.
// Assumes the block samples strobes through synchronisers, no ready line.
`timescale 1ns/10ps

module host_bus_model (
   input wire logic core_clk,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic bus_high_enable_n,
   output logic [15:0] addr,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic rdata_oe
);
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // Idle bus at time zero.
   initial begin
      rd_strobe = 1'b0;
      wr_strobe = 1'b0;
      bus_high_enable_n = 1'b1;
      addr = 16'h0000;
      wdata = 16'h0000;
   end

   task automatic gap(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Address and data settle two cycles before the strobe, held to its end.
   // high enable low
   task automatic write(input logic [15:0] a, input logic [15:0] d, input logic hi_n);
      addr = a;
      wdata = d;
      bus_high_enable_n = hi_n;
      gap(2);
      wr_strobe = 1'b1;
      gap(4);
      wr_strobe = 1'b0;
      gap(1);
      wdata = ~d; // Released data must not look like the old value.
      bus_high_enable_n = 1'b1;
      gap(3);
   endtask

   // The answer lags the strobe by three edges, so it is taken after five.
   task automatic read(input logic [15:0] a, input logic hi_n, output logic [15:0] d,
                       output logic oe);
      addr = a;
      bus_high_enable_n = hi_n;
      gap(2);
      rd_strobe = 1'b1;
      gap(5);
      d = rdata;
      oe = rdata_oe;
      rd_strobe = 1'b0;
      bus_high_enable_n = 1'b1;
      gap(4);
   endtask
endmodule

// ### io_port_control_register_decode_tb.sv
// Self-checking bench for the port register window and select terms.
// Assumes the host model and the design files are compiled beforehand.
`timescale 1ns/10ps
`include "ioport_params.svh"

module io_port_control_register_decode_tb;
   localparam logic [15:0] BASE = 16'h4800;
   logic core_clk, reset, bus_wide;
   logic rd_strobe, wr_strobe, bus_high_enable_n, rdata_oe;
   logic [15:0] addr, wdata, rdata;
   logic [`TERM_COUNT-1:0][`DEC_W-1:0] care, match;
   logic [7:0] route_b, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, ext_a, ext_b;
   logic [2:0] route_c, pc_in, pc_out, pc_oe, ext_c, single_sel;
   logic [3:0] wide_sel, narrow_sel;
   logic [7:0] power, page;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // Pads: the wire shows the block where it drives, else the outside.
   // ---------------------------------------------------------------
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
   assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);

   host_bus_model host (.core_clk(core_clk), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
      .bus_high_enable_n(bus_high_enable_n), .addr(addr), .wdata(wdata), .rdata(rdata),
      .rdata_oe(rdata_oe));

   io_port_control_register_decode dut (.core_clk(core_clk), .reset(reset),
      .bus_wide(bus_wide), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
      .bus_high_enable_n(bus_high_enable_n), .addr(addr), .wdata(wdata), .rdata(rdata),
      .rdata_oe(rdata_oe), .term_care(care), .term_match(match), .route_b(route_b),
      .route_c(route_c), .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
      .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe), .port_c_in(pc_in),
      .port_c_out(pc_out), .port_c_oe(pc_oe), .wide_term_selects(wide_sel),
      .narrow_term_selects(narrow_sel), .single_term_selects(single_sel),
      .power_saving_control(power), .page_select(page));

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] pin(input logic [7:0] o, input logic [7:0] d,
                                      input logic [7:0] e);
      return (o & d) | (~o & e);
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   // Narrow reads carry only the low lane, so the high byte is not judged.
   task automatic rdchk(input string n, input logic [15:0] a, input logic hi_n,
                        input logic [15:0] e, input logic eoe);
      logic [15:0] d;
      logic oe;
      host.read(a, hi_n, d, oe);
      chk(n, {15'h0000, eoe}, {15'h0000, oe});
      if (eoe && !bus_wide) d[15:8] = 8'h00;
      if (eoe) chk(n, e, d);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk("dir a", 16'h0000, pa_oe);
      chk("latch b", 16'h0000, pb_out);
      chk("dir b", 16'h0000, pb_oe);
      chk("latch a", 16'h0000, pa_out);
      $display("reset test done");
   endtask

   task automatic t_narrow;
      host.write(BASE | 16'h4, 16'h00a5, 1'b1);
      host.write(BASE | 16'h6, 16'h003c, 1'b1);
      host.write(BASE | 16'h5, 16'h005a, 1'b1);
      host.write(BASE | 16'h7, 16'h00c3, 1'b1);
      chk("dir a", 16'h00a5, pa_oe);
      chk("latch a", 16'h003c, pa_out);
      chk("dir b", 16'h005a, pb_oe);
      chk("latch b", 16'h00c3, pb_out);
      rdchk("rd dir a", BASE | 16'h4, 1'b1, 16'h00a5, 1'b1);
      rdchk("alias dir a", BASE | 16'h24, 1'b1, 16'h00a5, 1'b1);
      rdchk("rd latch b", BASE | 16'h7, 1'b1, 16'h00c3, 1'b1);
      host.write(BASE | 16'h2, 16'h00ff, 1'b1); // Pin levels cannot be written.
      chk("pin write", 16'h00a5, pa_oe);
      rdchk("pin a", BASE | 16'h2, 1'b1, {8'h00, pin(8'ha5, 8'h3c, ext_a)}, 1'b1);
      rdchk("pin b", BASE | 16'h3, 1'b1, {8'h00, pin(8'h5a, 8'hc3, ext_b)}, 1'b1);
      rdchk("hole", BASE | 16'h8, 1'b1, 16'h0000, 1'b0);
      rdchk("outside", 16'h5004, 1'b1, 16'h0000, 1'b0);
      host.write(16'h5004, 16'h0000, 1'b1);
      chk("dir a kept", 16'h00a5, pa_oe);
      host.write(BASE | 16'h10, 16'h0081, 1'b1);
      host.write(BASE | 16'h18, 16'h007e, 1'b1);
      chk("power", 16'h0081, power);
      chk("page", 16'h007e, page);
      rdchk("rd power", BASE | 16'h10, 1'b1, 16'h0081, 1'b1);
      $display("narrow test done");
   endtask

   task automatic t_wide;
      bus_wide = 1'b1;
      host.gap(4);
      host.write(BASE | 16'h4, 16'h1234, 1'b0);
      chk("dir a", 16'h0034, pa_oe);
      chk("dir b", 16'h0012, pb_oe);
      rdchk("rd dir", BASE | 16'h4, 1'b0, 16'h1234, 1'b1);
      host.write(BASE | 16'h6, 16'haa77, 1'b1);
      chk("latch a", 16'h0077, pa_out);
      chk("latch b kept", 16'h00c3, pb_out);
      host.write(BASE | 16'h7, 16'h9900, 1'b0);
      chk("latch b", 16'h0099, pb_out);
      chk("latch a kept", 16'h0077, pa_out);
      rdchk("pins", BASE | 16'h2, 1'b0,
            {pin(8'h12, 8'h99, ext_b), pin(8'h34, 8'h77, ext_a)}, 1'b1);
      host.write(BASE | 16'h18, 16'h0055, 1'b1);
      chk("page", 16'h0055, page);
      $display("wide test done");
   endtask

   // Port C pin 0 carries single select 0 back into the terms of wide select 0.
   task automatic t_sel;
      route_b = 8'h11;
      route_c = 3'b001;
      ext_c = 3'b100;
      host.gap(10);
      chk("wide c100", 16'h0001, wide_sel);
      chk("narrow c100", 16'h0000, narrow_sel);
      chk("pb pins c100", 16'h0001, {pb_out[4], pb_out[0]});
      ext_c = 3'b010;
      host.gap(10);
      chk("single c010", 16'h0001, single_sel);
      chk("pc pin", 16'h0003, {pc_oe[0], pc_out[0]});
      chk("wide c011", 16'h0001, wide_sel);
      chk("narrow c011", 16'h0001, narrow_sel);
      ext_c = 3'b000;
      host.gap(10);
      chk("wide c000", 16'h0000, wide_sel);
      chk("pb pins c000", 16'h0002, {pb_out[4], pb_out[0]});
      chk("single c000", 16'h0000, single_sel);
      $display("select test done");
   endtask

   // ---------------------------------------------------------------
   // Clock, hang guard and main sequence
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // The whole run needs well under a thousand cycles.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // Unused terms need all-ones inputs, which no scenario produces.
   initial begin
      reset = 1'b1;
      bus_wide = 1'b0;
      route_b = 8'h00;
      route_c = 3'b000;
      ext_a = 8'h0f;
      ext_b = 8'hf0;
      ext_c = 3'b000;
      for (int i = 0; i < `TERM_COUNT; i++) begin
         care[i] = 11'h7ff;
         match[i] = 11'h7ff;
      end
      care[0] = 11'h003;
      match[0] = 11'h003;
      care[1] = 11'h004;
      match[1] = 11'h004;
      care[16] = 11'h004;
      match[16] = 11'h000;
      care[24] = 11'h002;
      match[24] = 11'h002;
      care[27] = 11'h7f8;
      match[27] = 11'h240;
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      host.gap(3);
      t_reset();
      t_narrow();
      t_wide();
      t_sel();
      stop_test();
   end
endmodule
